//--- hdl/ffo_top.sv
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "ffo_consts.svh"

module ffo_top
  import ffo_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`FFO_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Strap pins
  input wire logic offset_select_lo,
  input wire logic offset_select_hi,
  input wire logic load_method_pin,
  // Write side
  input wire logic wr_en,
  input wire logic [`FFO_DATA_W-1:0] wr_data,
  output logic input_ready_n,
  output logic almost_full_n,
  output logic half_full_n,
  // Read side
  input wire logic rd_en,
  output logic [`FFO_DATA_W-1:0] parallel_data_out,
  output logic output_ready_n,
  output logic almost_empty_n,
  // Interrupt
  output logic irq
);
  // ==========================================================================
  // Strap capture
  logic [2:0] strap_meta_reg;
  logic [2:0] strap_sync_reg;
  ffo_strap_state_type strap_state_reg;
  logic serial_mode_reg;
  logic [`FFO_OFS_W-1:0] empty_ofs_reg;
  logic [`FFO_OFS_W-1:0] full_ofs_reg;
  logic [`FFO_OFS_W-1:0] default_ofs;
  logic strap_take;

  // The synchroniser keeps running in reset, so settled straps wait there when taken.
  always_ff @(posedge pclk) begin
    strap_meta_reg <= {load_method_pin, offset_select_hi, offset_select_lo};
    strap_sync_reg <= strap_meta_reg;
  end

  // Straps are taken only once the synchroniser has filled after release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_state_reg <= ST_SYNC0;
    end else begin
      unique case (strap_state_reg)
        ST_SYNC0: strap_state_reg <= ST_SYNC1;
        ST_SYNC1: strap_state_reg <= ST_RUN;
        ST_RUN: strap_state_reg <= ST_RUN;
        default: strap_state_reg <= ST_SYNC0;
      endcase
    end
  end

  assign strap_take = (strap_state_reg == ST_SYNC1);

  always_comb begin
    unique case (strap_sync_reg)
      3'b100: default_ofs = `FFO_DEF_HLL;
      3'b010: default_ofs = `FFO_DEF_LHL;
      3'b001: default_ofs = `FFO_DEF_LLH;
      3'b000: default_ofs = `FFO_DEF_LLL;
      3'b011: default_ofs = `FFO_DEF_LHH;
      3'b110: default_ofs = `FFO_DEF_HHL;
      3'b101: default_ofs = `FFO_DEF_HLH;
      3'b111: default_ofs = `FFO_DEF_HHH;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_mode_reg <= 1'b0;
    end else if (strap_take) begin
      serial_mode_reg <= strap_sync_reg[2];
    end
  end

  // ==========================================================================
  // APB decode
  logic apb_wr;
  logic apb_rd;
  logic addr_ok;
  ffo_readback_type readback_reg;
  logic [`FFO_INT_W-1:0] int_stat_reg;
  logic [`FFO_INT_W-1:0] int_mask_reg;
  logic [`FFO_INT_W-1:0] int_event;
  logic [`FFO_CNT_W-1:0] fill_reg;

  assign addr_ok = (paddr == `FFO_ADDR_CTRL) || (paddr == `FFO_ADDR_EMPTY_OFS) ||
                   (paddr == `FFO_ADDR_FULL_OFS) || (paddr == `FFO_ADDR_SERIAL_IN) ||
                   (paddr == `FFO_ADDR_STATUS) || (paddr == `FFO_ADDR_INT_STAT) ||
                   (paddr == `FFO_ADDR_INT_MASK);
  assign apb_wr = psel && penable && pwrite && addr_ok;
  assign apb_rd = psel && penable && !pwrite && addr_ok;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      `FFO_ADDR_CTRL: prdata[1:0] = readback_reg;
      `FFO_ADDR_EMPTY_OFS: prdata[`FFO_OFS_W-1:0] = empty_ofs_reg;
      `FFO_ADDR_FULL_OFS: prdata[`FFO_OFS_W-1:0] = full_ofs_reg;
      `FFO_ADDR_STATUS: begin
        prdata[`FFO_CNT_W-1:0] = fill_reg;
        prdata[`FFO_STAT_SERIAL_BIT] = serial_mode_reg;
        prdata[`FFO_STAT_READY_BIT] = (strap_state_reg == ST_RUN);
      end
      `FFO_ADDR_INT_STAT: prdata[`FFO_INT_W-1:0] = int_stat_reg;
      `FFO_ADDR_INT_MASK: prdata[`FFO_INT_W-1:0] = int_mask_reg;
      default: prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      readback_reg <= RB_OFF;
    end else if (apb_wr && paddr == `FFO_ADDR_CTRL) begin
      readback_reg <= ffo_readback_type'(pwdata[1:0]);
    end
  end

  // ==========================================================================
  // Offset registers
  // Parallel writes land whole; serial writes shift one bit through {full, empty}.
  // Values above depth minus one are not checked; software keeps them in range.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty_ofs_reg <= `FFO_OFS_RESET;
      full_ofs_reg <= `FFO_OFS_RESET;
    end else if (strap_take) begin
      empty_ofs_reg <= default_ofs;
      full_ofs_reg <= default_ofs;
    end else if (apb_wr && !serial_mode_reg && paddr == `FFO_ADDR_EMPTY_OFS) begin
      empty_ofs_reg <= pwdata[`FFO_OFS_W-1:0];
    end else if (apb_wr && !serial_mode_reg && paddr == `FFO_ADDR_FULL_OFS) begin
      full_ofs_reg <= pwdata[`FFO_OFS_W-1:0];
    end else if (apb_wr && serial_mode_reg && paddr == `FFO_ADDR_SERIAL_IN) begin
      {full_ofs_reg, empty_ofs_reg} <= {full_ofs_reg[`FFO_OFS_W-2:0], empty_ofs_reg,
                                        pwdata[0]};
    end
  end

  // ==========================================================================
  // Storage and output register
  logic [`FFO_PTR_W-1:0] wr_ptr_reg;
  logic [`FFO_PTR_W-1:0] rd_ptr_reg;
  logic [`FFO_CNT_W-1:0] ram_cnt_reg;
  logic fetch_pend_reg;
  logic head_valid_reg;
  logic [`FFO_DATA_W-1:0] head_reg;
  logic [`FFO_DATA_W-1:0] ram_rd_data;
  logic wr_ok;
  logic pop;
  logic fetch;

  assign wr_ok = wr_en && (fill_reg != `FFO_CAPACITY);
  assign pop = rd_en && head_valid_reg && !output_ready_n;
  assign fetch = (ram_cnt_reg != 12'h000) && !fetch_pend_reg && (!head_valid_reg || pop);

  ffo_ram u_ram (
    .pclk(pclk),
    .wr_en(wr_ok),
    .wr_addr(wr_ptr_reg),
    .wr_data(wr_data),
    .rd_en(fetch),
    .rd_addr(rd_ptr_reg),
    .rd_data(ram_rd_data)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= 11'h000;
      rd_ptr_reg <= 11'h000;
      ram_cnt_reg <= 12'h000;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + 11'(wr_ok);
      rd_ptr_reg <= rd_ptr_reg + 11'(fetch);
      ram_cnt_reg <= ram_cnt_reg + 12'(wr_ok) - 12'(fetch);
    end
  end

  // The output register counts toward capacity, giving depth plus one words.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_pend_reg <= 1'b0;
      head_valid_reg <= 1'b0;
      head_reg <= 18'h00000;
    end else begin
      fetch_pend_reg <= fetch;
      if (fetch_pend_reg) begin
        head_valid_reg <= 1'b1;
        head_reg <= ram_rd_data;
      end else if (pop) begin
        head_valid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_reg <= 12'h000;
    end else begin
      fill_reg <= fill_reg + 12'(wr_ok) - 12'(pop);
    end
  end

  // Offset readback shares the data port, so it hides the head word while selected.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parallel_data_out <= 18'h00000;
    end else begin
      unique case (readback_reg)
        RB_EMPTY: parallel_data_out <= 18'(empty_ofs_reg);
        RB_FULL: parallel_data_out <= 18'(full_ofs_reg);
        default: parallel_data_out <= head_reg;
      endcase
    end
  end

  // ==========================================================================
  // Status flags
  logic [`FFO_CNT_W-1:0] full_thresh;
  logic [`FFO_CNT_W-1:0] empty_thresh;
  logic [2:0] or_pipe_reg;
  logic [1:0] ir_pipe_reg;

  assign full_thresh = `FFO_CAPACITY - 12'(full_ofs_reg);
  assign empty_thresh = 12'(empty_ofs_reg) + 12'h001;

  // Deeper flag pipes cost latency; software and partners must tolerate stale flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      or_pipe_reg <= 3'b111;
      ir_pipe_reg <= 2'b00;
    end else begin
      // The stored count, not the head register, so a refill gap never flags empty.
      or_pipe_reg <= {or_pipe_reg[1:0], fill_reg == 12'h000};
      ir_pipe_reg <= {ir_pipe_reg[0], fill_reg == `FFO_CAPACITY};
    end
  end

  assign output_ready_n = or_pipe_reg[2];
  assign input_ready_n = ir_pipe_reg[1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      almost_full_n <= 1'b1;
      half_full_n <= 1'b1;
      almost_empty_n <= 1'b0;
    end else begin
      almost_full_n <= !(fill_reg >= full_thresh);
      half_full_n <= !(fill_reg >= `FFO_HALF_LEVEL);
      almost_empty_n <= !(fill_reg <= empty_thresh);
    end
  end

  // ==========================================================================
  // Interrupts
  logic full_d_reg;
  logic empty_d_reg;
  logic af_d_reg;
  logic ae_d_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_d_reg <= 1'b0;
      empty_d_reg <= 1'b1;
      af_d_reg <= 1'b1;
      ae_d_reg <= 1'b0;
    end else begin
      full_d_reg <= input_ready_n;
      empty_d_reg <= output_ready_n;
      af_d_reg <= almost_full_n;
      ae_d_reg <= almost_empty_n;
    end
  end

  always_comb begin
    int_event = '0;
    int_event[`FFO_INT_FULL] = input_ready_n && !full_d_reg;
    int_event[`FFO_INT_EMPTY] = output_ready_n && !empty_d_reg;
    int_event[`FFO_INT_ALMOST_FULL] = !almost_full_n && af_d_reg;
    int_event[`FFO_INT_ALMOST_EMPTY] = !almost_empty_n && ae_d_reg;
    int_event[`FFO_INT_OVERFLOW] = wr_en && !wr_ok;
  end

  // A read clears the status, but an event in the same cycle is kept.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_reg <= '0;
    end else if (apb_rd && paddr == `FFO_ADDR_INT_STAT) begin
      int_stat_reg <= int_event;
    end else begin
      int_stat_reg <= int_stat_reg | int_event;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask_reg <= '0;
    end else if (apb_wr && paddr == `FFO_ADDR_INT_MASK) begin
      int_mask_reg <= pwdata[`FFO_INT_W-1:0];
    end
  end

  assign irq = |(int_stat_reg & int_mask_reg);
endmodule

//--- common/ffo_consts.svh
// Overview of operation
// - At reset, straps and load pin pick one of eight default offsets, 7 to 1023.
// - Either load method also preloads the strap-selected default offsets.
// - Capacity is memory depth plus one output-register word before full.
// - A read from full drops input_ready_n low so writes may resume.
// - Further reads release almost_full_n, then half_full_n, as level falls.
// - almost_empty_n asserts low once level is at most empty offset plus one.
// - Reading the last word raises output_ready_n; reads while empty are ignored.
// - output_ready_n passes three register stages, input_ready_n two.
// - Empty and full offsets live in user-writable registers replacing defaults.
// - Load pin held in reset; high picks serial loading, low parallel.
// - Offsets read back on parallel_data_out in both modes; no serial readback.
// - Offsets reprogrammable any time after reset; software keeps them below depth.
// - When full, input_ready_n goes high and further writes are refused.
// - First word into empty FIFO drops output_ready_n and shows that word.
`ifndef FFO_CONSTS_SVH
`define FFO_CONSTS_SVH

// ==========================================================================
// Geometry
`define FFO_DATA_W 18
`define FFO_MEM_DEPTH 2048
`define FFO_PTR_W 11
`define FFO_CNT_W 12
`define FFO_OFS_W 11
`define FFO_CAPACITY 12'h801
`define FFO_HALF_LEVEL 12'h402

// ==========================================================================
// Register map, byte addresses
`define FFO_ADDR_W 8
`define FFO_ADDR_CTRL 8'h00
`define FFO_ADDR_EMPTY_OFS 8'h04
`define FFO_ADDR_FULL_OFS 8'h08
`define FFO_ADDR_SERIAL_IN 8'h0C
`define FFO_ADDR_STATUS 8'h10
`define FFO_ADDR_INT_STAT 8'h14
`define FFO_ADDR_INT_MASK 8'h18

// ==========================================================================
// Fields and reset values
`define FFO_STAT_SERIAL_BIT 16
`define FFO_STAT_READY_BIT 17
`define FFO_INT_W 5
`define FFO_INT_FULL 0
`define FFO_INT_EMPTY 1
`define FFO_INT_ALMOST_FULL 2
`define FFO_INT_ALMOST_EMPTY 3
`define FFO_INT_OVERFLOW 4
`define FFO_OFS_RESET 11'h07F

// ==========================================================================
// Default offsets by strap code {load, hi, lo}
`define FFO_DEF_HLL 11'h3FF
`define FFO_DEF_LHL 11'h1FF
`define FFO_DEF_LLH 11'h0FF
`define FFO_DEF_LLL 11'h07F
`define FFO_DEF_LHH 11'h03F
`define FFO_DEF_HHL 11'h01F
`define FFO_DEF_HLH 11'h00F
`define FFO_DEF_HHH 11'h007

`endif

//--- common/ffo_pkg.sv
package ffo_pkg;
  typedef enum logic [1:0] {
    ST_SYNC0 = 2'b00,
    ST_SYNC1 = 2'b01,
    ST_RUN = 2'b10
  } ffo_strap_state_type;

  typedef enum logic [1:0] {
    RB_OFF = 2'b00,
    RB_EMPTY = 2'b01,
    RB_FULL = 2'b10,
    RB_RSVD = 2'b11
  } ffo_readback_type;
endpackage

//--- hdl/ffo_ram.sv
`timescale 1ns/100ps
`include "ffo_consts.svh"

module ffo_ram (
  // Clock
  input wire logic pclk,
  // Write port
  input wire logic wr_en,
  input wire logic [`FFO_PTR_W-1:0] wr_addr,
  input wire logic [`FFO_DATA_W-1:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [`FFO_PTR_W-1:0] rd_addr,
  output logic [`FFO_DATA_W-1:0] rd_data
);
  // ==========================================================================
  // Storage
  // Read-first so a read and write to one address in a cycle return old data.
  logic [`FFO_DATA_W-1:0] mem [0:`FFO_MEM_DEPTH-1];

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge pclk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

//--- testbench/ffo_top_sva.sv
`timescale 1ns/100ps
`include "ffo_consts.svh"

module ffo_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`FFO_ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Pins and flags
  input wire logic load_method_pin,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic input_ready_n,
  input wire logic output_ready_n,
  input wire logic half_full_n,
  input wire logic irq
);
  // ==========================================================================
  // Helper logic
  logic [3:0] rd_gap_reg;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // The count saturates, so a long idle spell never wraps back into range.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_gap_reg <= 4'hF;
    end else if (rd_en) begin
      rd_gap_reg <= 4'h0;
    end else if (rd_gap_reg != 4'hF) begin
      rd_gap_reg <= rd_gap_reg + 4'h1;
    end
  end
  // ==========================================================================
  // Assertions
  bad_addr_a: assert property (psel && penable && paddr > 8'h18
    |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused.");
  serial_mode_a: assert property (psel && penable && !pwrite && paddr == `FFO_ADDR_STATUS
    |-> prdata[17:16] == {1'b1, load_method_pin})
    else $error("load method not reported.");
  full_half_a: assert property (input_ready_n |-> !half_full_n)
    else $error("full without half full.");
  ready_rise_a: assert property ($rose(input_ready_n)
    |-> $past(wr_en, 2) || $past(wr_en, 3))
    else $error("input ready rose without writes.");
  write_resume_a: assert property ($fell(input_ready_n) |-> rd_gap_reg < 4'h8)
    else $error("input ready fell without a read.");
  empty_rise_a: assert property ($rose(output_ready_n) |-> rd_gap_reg < 4'hA)
    else $error("output ready rose without a read.");
  half_ready_a: assert property (!half_full_n |-> !output_ready_n)
    else $error("half full while no word shown.");
  reset_flags_a: assert property ($rose(presetn)
    |-> output_ready_n && !input_ready_n && !irq)
    else $error("flags wrong after reset.");
  cover property ($rose(input_ready_n));
  cover property ($fell(input_ready_n));
  cover property ($rose(output_ready_n));
  cover property (psel && penable && pslverr);
endmodule

bind ffo_top ffo_chk ffo_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pslverr, .load_method_pin, .wr_en, .rd_en, .input_ready_n, .output_ready_n, .half_full_n,
  .irq);

//--- testbench/ffo_peer.sv
`timescale 1ns/100ps
`include "ffo_consts.svh"

module ffo_peer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests
  input wire logic go,
  input wire logic [11:0] wr_num,
  input wire logic [11:0] rd_num,
  // FIFO side
  output logic wr_en,
  output logic [`FFO_DATA_W-1:0] wr_data,
  output logic rd_en,
  output logic busy
);
  logic [11:0] wr_left_reg;
  logic [11:0] rd_left_reg;
  logic [2:0] gap_reg;
  logic [`FFO_DATA_W-1:0] seq_reg;
  // Idle data shows the inverse word, so a write taken without wr_en is seen.
  assign wr_data = wr_en ? seq_reg : ~seq_reg;
  // The writer ignores input_ready_n, as careless logic would
  assign wr_en = wr_left_reg != 12'h0;
  assign busy = wr_en || rd_en || rd_left_reg != 12'h0 || gap_reg != 3'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_left_reg <= 12'h0;
      seq_reg <= 18'h00000;
    end else if (go) begin
      wr_left_reg <= wr_num;
    end else if (wr_en) begin
      wr_left_reg <= wr_left_reg - 12'h1;
      seq_reg <= seq_reg + 18'h00001;
    end
  end
  // Reads pulse every eighth cycle, also while empty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_left_reg <= 12'h0;
      gap_reg <= 3'h0;
      rd_en <= 1'b0;
    end else if (go) begin
      rd_left_reg <= rd_num;
    end else if (rd_left_reg != 12'h0 && gap_reg == 3'h0) begin
      rd_en <= 1'b1;
      rd_left_reg <= rd_left_reg - 12'h1;
      gap_reg <= 3'h7;
    end else begin
      rd_en <= 1'b0;
      gap_reg <= gap_reg - {2'h0, gap_reg != 3'h0};
    end
  end
endmodule

//--- testbench/tb_ffo_top.sv
`timescale 1ns/100ps
`include "ffo_consts.svh"

module tb_ffo_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, errq, go, busy, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdq;
  logic offset_select_lo, offset_select_hi, load_method_pin, wr_en, rd_en;
  logic [17:0] wr_data, parallel_data_out;
  logic input_ready_n, output_ready_n, almost_full_n, half_full_n, almost_empty_n;
  logic [11:0] wr_num, rd_num;
  int errors, cmp_count;

  ffo_top ffo_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .offset_select_lo, .offset_select_hi, .load_method_pin, .wr_en, .wr_data,
    .input_ready_n, .almost_full_n, .half_full_n, .rd_en, .parallel_data_out, .output_ready_n,
    .almost_empty_n, .irq);
  ffo_peer ffo_peer_inst (.pclk, .presetn, .go, .wr_num, .rd_num, .wr_en, .wr_data, .rd_en,
    .busy);

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ==========================================================================
  // Shared tasks
  task automatic end_of_test;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang;
    errors++;
    $display("FAIL %0t wait ran out", $time);
    end_of_test();
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) hang();
    rdq = prdata;
    errq = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdreg(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdq, e);
  endtask

  task automatic do_reset(input logic [2:0] code);
    @(posedge pclk);
    presetn <= 1'b0;
    {load_method_pin, offset_select_hi, offset_select_lo} <= code;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask

  // The peer is told how many words to move, then the bench waits for it to finish.
  task automatic run(input logic [11:0] w, input logic [11:0] r);
    int i;
    @(posedge pclk);
    wr_num <= w;
    rd_num <= r;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    for (i = 0; i < 20000; i++) begin
      @(posedge pclk);
      #1;
      if (busy === 1'b0) break;
    end
    if (i == 20000) hang();
    repeat (8) @(posedge pclk);
    #1;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_defaults;
    logic [10:0] tab [8];
    int c;
    tab = '{11'h07F, 11'h0FF, 11'h1FF, 11'h03F, 11'h3FF, 11'h00F, 11'h01F, 11'h007};
    for (c = 0; c < 8; c++) begin
      do_reset(c[2:0]);
      rdreg(`FFO_ADDR_EMPTY_OFS, {21'h0, tab[c]});
      rdreg(`FFO_ADDR_FULL_OFS, {21'h0, tab[c]});
      apb(1'b0, `FFO_ADDR_STATUS, 32'h0);
      chk(rdq[17:16], {1'b1, c[2]});
      apb(1'b1, `FFO_ADDR_CTRL, 32'h1);
      repeat (4) @(posedge pclk);
      chk(parallel_data_out, tab[c]);
    end
  endtask

  task automatic t_serial;
    logic [21:0] v;
    int i;
    v = {11'h00A, 11'h002};
    do_reset(3'b111);
    for (i = 21; i >= 0; i--) apb(1'b1, `FFO_ADDR_SERIAL_IN, {31'h0, v[i]});
    apb(1'b1, `FFO_ADDR_EMPTY_OFS, 32'h9);
    rdreg(`FFO_ADDR_EMPTY_OFS, 32'h2);
    rdreg(`FFO_ADDR_FULL_OFS, 32'hA);
    apb(1'b1, `FFO_ADDR_CTRL, 32'h2);
    repeat (4) @(posedge pclk);
    chk(parallel_data_out, 18'h0000A);
  endtask

  task automatic t_parallel;
    do_reset(3'b000);
    apb(1'b1, `FFO_ADDR_EMPTY_OFS, 32'h3);
    apb(1'b1, `FFO_ADDR_FULL_OFS, 32'h5);
    apb(1'b1, `FFO_ADDR_SERIAL_IN, 32'h1);
    rdreg(`FFO_ADDR_EMPTY_OFS, 32'h3);
    rdreg(`FFO_ADDR_FULL_OFS, 32'h5);
    apb(1'b0, 8'h40, 32'h0);
    chk(rdq, 32'h0);
    chk(errq, 1'b1);
  endtask

  // Empty offset 3 and full offset 5 stand from the parallel scenario.
  task automatic t_stream;
    apb(1'b1, `FFO_ADDR_INT_MASK, 32'h10);
    run(12'd1, 12'd0);
    chk({output_ready_n, almost_empty_n, parallel_data_out}, 20'h0);
    run(12'd0, 12'd3);
    chk(output_ready_n, 1'b1);
    run(12'd2052, 12'd0);
    chk({input_ready_n, almost_full_n, half_full_n, irq}, 4'h9);
    chk(parallel_data_out, 18'h00001);
    apb(1'b0, `FFO_ADDR_STATUS, 32'h0);
    chk(rdq[11:0], 12'h801);
    apb(1'b1, `FFO_ADDR_INT_MASK, 32'h0);
    run(12'd0, 12'd0);
    chk(irq, 1'b0);
    apb(1'b1, `FFO_ADDR_INT_MASK, 32'h10);
    apb(1'b0, `FFO_ADDR_INT_STAT, 32'h0);
    run(12'd0, 12'd0);
    chk({rdq[4:0], irq}, 6'b101110);
    run(12'd0, 12'd1);
    chk(input_ready_n, 1'b0);
    run(12'd0, 12'd4);
    chk(almost_full_n, 1'b0);
    run(12'd0, 12'd1);
    chk({almost_full_n, half_full_n}, 2'b10);
    run(12'd0, 12'd1017);
    chk(half_full_n, 1'b0);
    run(12'd0, 12'd1);
    chk(half_full_n, 1'b1);
    run(12'd0, 12'd1020);
    chk(almost_empty_n, 1'b1);
    run(12'd0, 12'd1);
    chk(almost_empty_n, 1'b0);
    run(12'd0, 12'd6);
    chk(output_ready_n, 1'b1);
    apb(1'b0, `FFO_ADDR_STATUS, 32'h0);
    chk(rdq[11:0], 12'h000);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, go, wr_num, rd_num} = '0;
    {offset_select_lo, offset_select_hi, load_method_pin} = 3'b000;
    errors = 0;
    cmp_count = 0;
    t_defaults();
    t_serial();
    t_parallel();
    t_stream();
    end_of_test();
  end
endmodule
